//--- design/dcc_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the dual
 * comparator control block. Included by the package user modules by bare name.
 */
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH

`define DCC_ADDR_W 8
`define DCC_OFF_CN1 8'h9a
`define DCC_OFF_CN0 8'h9b
`define DCC_OFF_MD1 8'h9c
`define DCC_OFF_MD0 8'h9d
`define DCC_OFF_MX0 8'h9f
`define DCC_OFF_MX1 8'h9e
`define DCC_OFF_RST 8'ha0

`define DCC_CN_EN 7
`define DCC_CN_OUT 6
`define DCC_CN_RIF 5
`define DCC_CN_FIF 4
`define DCC_CN_HYP 2
`define DCC_CN_HYN 0
`define DCC_MD_RIE 5
`define DCC_MD_FIE 4
`define DCC_MD_MODE 0
`define DCC_MX_NEG 4
`define DCC_MX_POS 0
`define DCC_RST_EN 0

`define DCC_CN_RESET 8'h00
`define DCC_MD_RESET 8'h02
`define DCC_MX_RESET 8'h00
`define DCC_RST_RESET 8'h00
`define DCC_SYNC_STAGES 2

`endif

//--- design/dcc_pkg.sv
/*
 * Types of the dual comparator control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dcc_pkg;

    typedef struct packed {
        logic enable;
        logic riseFlag;
        logic fallFlag;
        logic [1:0] posHyst;
        logic [1:0] negHyst;
        logic riseIrqEn;
        logic fallIrqEn;
        logic [1:0] respMode;
        logic [1:0] posSel;
        logic [1:0] negSel;
    } dcc_cfg_t;

    typedef struct packed {
        logic result;
        logic latched;
        logic irq;
    } dcc_stat_t;

    typedef struct packed {
        logic [1:0] posSel;
        logic [1:0] negSel;
        logic [1:0] posHyst;
        logic [1:0] negHyst;
        logic [1:0] respMode;
        logic enable;
    } dcc_analog_t;

endpackage

//--- design/dcc_sync.sv
/*
 * Two-stage synchroniser for one level.
 * Assumes the input may change at any time relative to clk.
 */
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module dcc_sync (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic [`DCC_SYNC_STAGES-1:0] stages;
    } dcc_sync_state_t;

    dcc_sync_state_t state_reg;
    dcc_sync_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (clkEn) begin
            state_next.stages = {state_reg.stages[0], din};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.stages[`DCC_SYNC_STAGES-1];
endmodule

//--- design/dcc_unit.sv
/*
 * One comparator's digital side: enable gating, synchronised result,
 * edge flags with set-over-clear, interrupt request.
 * Assumes rawCmp comes from the analog comparator, unclocked.
 */
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module dcc_unit (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic rawCmp,
    input wire logic enable,
    input wire logic riseIrqEn,
    input wire logic fallIrqEn,
    input wire logic clrRise,
    input wire logic clrFall,
    output logic rawOut,
    output logic riseFlag,
    output logic fallFlag,
    output dcc_pkg::dcc_stat_t stat
);
    typedef struct packed {
        logic prev;
        logic rise;
        logic fall;
        logic latched;
        logic irq;
    } dcc_unit_state_t;

    dcc_unit_state_t state_reg;
    dcc_unit_state_t state_next;
    logic syncOut;
    logic riseEv;
    logic fallEv;

    // unclocked gated path
    // The raw output needs no clock, so it keeps working in stop mode.
    assign rawOut = rawCmp & enable;

    dcc_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .din(rawOut),
        .dout(syncOut)
    );

    assign riseEv = syncOut & ~state_reg.prev;
    assign fallEv = ~syncOut & state_reg.prev;

    always_comb begin
        state_next = state_reg;
        if (clkEn) begin
            state_next.prev = syncOut;
            state_next.latched = syncOut & enable;
            state_next.rise = riseEv | (state_reg.rise & ~clrRise);
            state_next.fall = fallEv | (state_reg.fall & ~clrFall);
            state_next.irq = (state_next.rise & riseIrqEn) | (state_next.fall & fallIrqEn);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign riseFlag = state_reg.rise;
    assign fallFlag = state_reg.fall;
    assign stat.result = state_reg.prev;
    assign stat.latched = state_reg.latched;
    assign stat.irq = state_reg.irq;
endmodule

//--- design/dcc_top.sv
/*
 * Dual comparator control: registers, two comparator units, reset source.
 * Assumes a single-cycle register port and comparator results from analog.
 */
// Local design decisions: the address-and-strobe port and the address map.
// Contract
// - Two identical comparator units; input sets differ; only unit 0 resets.
// - Each unit offers a latched clocked output and a raw output.
// - Raw output works without the clock, also in stop mode.
// - Unit 0 can be selected as a device reset source.
// - Per-unit select register holds two-bit positive and negative input fields.
// - Result can be polled, raise interrupts and drive pins together.
// - A disabled comparator drives its routed outputs low.
// - Per-unit mode register holds a response-time setting.
// - Control bits three to zero set positive and negative hysteresis.
// - Rising and falling output transitions are separate events.
// - Falling edge sets the fall flag; rising edge sets the rise flag.
// - Edge flags are sticky until software writes zero.
// - Read-only result bit shows the current comparison.
// - Enable bit one switches the comparator on, zero off.
// - Spurious edges may be flagged after enabling or mode changes.
// - Hysteresis code 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
// - Mode 0 fastest, mode 3 lowest power; resets to mode 2.
// - Interrupt raised only for a set flag with its enable.
// - Result reads one when positive input exceeds negative.
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module dcc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [`DCC_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic rawCmp0,
    input wire logic rawCmp1,
    output logic cmp0_raw_out,
    output logic cmp1_raw_out,
    output logic cmp0_latched_out,
    output logic cmp1_latched_out,
    output logic cmp0Irq,
    output logic cmp1Irq,
    output logic cmpResetReq,
    output dcc_pkg::dcc_analog_t cmp0Analog,
    output dcc_pkg::dcc_analog_t cmp1Analog
);
    typedef struct packed {
        dcc_pkg::dcc_cfg_t c0;
        dcc_pkg::dcc_cfg_t c1;
        logic resetSrcEn;
        logic [7:0] rdata;
        logic resetReq;
    } dcc_top_state_t;

    dcc_top_state_t state_reg;
    dcc_top_state_t state_next;
    dcc_pkg::dcc_stat_t stat0;
    dcc_pkg::dcc_stat_t stat1;
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;
    logic clrRise0;
    logic clrFall0;
    logic clrRise1;
    logic clrFall1;
    logic wrCn0;
    logic wrCn1;
    logic raw0;
    logic raw1;

    assign wrCn0 = clkEn & regWr & (regAddr == `DCC_OFF_CN0);
    assign wrCn1 = clkEn & regWr & (regAddr == `DCC_OFF_CN1);
    assign clrRise0 = wrCn0 & ~regWdata[`DCC_CN_RIF];
    assign clrFall0 = wrCn0 & ~regWdata[`DCC_CN_FIF];
    assign clrRise1 = wrCn1 & ~regWdata[`DCC_CN_RIF];
    assign clrFall1 = wrCn1 & ~regWdata[`DCC_CN_FIF];

    dcc_unit u_cmp0 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .rawCmp(rawCmp0),
        .enable(state_reg.c0.enable),
        .riseIrqEn(state_reg.c0.riseIrqEn),
        .fallIrqEn(state_reg.c0.fallIrqEn),
        .clrRise(clrRise0),
        .clrFall(clrFall0),
        .rawOut(raw0),
        .riseFlag(rise0),
        .fallFlag(fall0),
        .stat(stat0)
    );

    dcc_unit u_cmp1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clkEn(clkEn),
        .rawCmp(rawCmp1),
        .enable(state_reg.c1.enable),
        .riseIrqEn(state_reg.c1.riseIrqEn),
        .fallIrqEn(state_reg.c1.fallIrqEn),
        .clrRise(clrRise1),
        .clrFall(clrFall1),
        .rawOut(raw1),
        .riseFlag(rise1),
        .fallFlag(fall1),
        .stat(stat1)
    );

    // raw outputs bypass every flop
    // A clocked copy would freeze in stop mode, so the raw path stays combinational.
    assign cmp0_raw_out = raw0;
    assign cmp1_raw_out = raw1;

    function automatic logic [7:0] cnRead(input dcc_pkg::dcc_cfg_t c,
                                          input logic res, input logic rf,
                                          input logic ff);
        logic [7:0] v;
        v = `DCC_CN_RESET;
        v[`DCC_CN_EN] = c.enable;
        v[`DCC_CN_OUT] = res;
        v[`DCC_CN_RIF] = rf;
        v[`DCC_CN_FIF] = ff;
        v[`DCC_CN_HYP +: 2] = c.posHyst;
        v[`DCC_CN_HYN +: 2] = c.negHyst;
        return v;
    endfunction

    function automatic logic [7:0] mdRead(input dcc_pkg::dcc_cfg_t c);
        logic [7:0] v;
        v = 8'h00;
        v[`DCC_MD_RIE] = c.riseIrqEn;
        v[`DCC_MD_FIE] = c.fallIrqEn;
        v[`DCC_MD_MODE +: 2] = c.respMode;
        return v;
    endfunction

    function automatic logic [7:0] mxRead(input dcc_pkg::dcc_cfg_t c);
        logic [7:0] v;
        v = 8'h00;
        v[`DCC_MX_NEG +: 2] = c.negSel;
        v[`DCC_MX_POS +: 2] = c.posSel;
        return v;
    endfunction

    function automatic logic [7:0] rstRead(input logic en);
        logic [7:0] v;
        v = `DCC_RST_RESET;
        v[`DCC_RST_EN] = en;
        return v;
    endfunction

    // reset values
    // Reset values come from the config header, so the map and the logic cannot drift apart.
    function automatic dcc_pkg::dcc_cfg_t cfgReset();
        logic [7:0] cn;
        logic [7:0] md;
        logic [7:0] mx;
        dcc_pkg::dcc_cfg_t c;
        cn = `DCC_CN_RESET;
        md = `DCC_MD_RESET;
        mx = `DCC_MX_RESET;
        c.enable = cn[`DCC_CN_EN];
        c.riseFlag = cn[`DCC_CN_RIF];
        c.fallFlag = cn[`DCC_CN_FIF];
        c.posHyst = cn[`DCC_CN_HYP +: 2];
        c.negHyst = cn[`DCC_CN_HYN +: 2];
        c.riseIrqEn = md[`DCC_MD_RIE];
        c.fallIrqEn = md[`DCC_MD_FIE];
        c.respMode = md[`DCC_MD_MODE +: 2];
        c.posSel = mx[`DCC_MX_POS +: 2];
        c.negSel = mx[`DCC_MX_NEG +: 2];
        return c;
    endfunction

    function automatic dcc_top_state_t topReset();
        logic [7:0] rs;
        dcc_top_state_t s;
        rs = `DCC_RST_RESET;
        s.c0 = cfgReset();
        s.c1 = cfgReset();
        s.resetSrcEn = rs[`DCC_RST_EN];
        s.rdata = 8'h00;
        s.resetReq = 1'h0;
        return s;
    endfunction

    always_comb begin
        state_next = state_reg;
        if (clkEn) begin
            if (regWr) begin
                unique case (regAddr)
                    `DCC_OFF_CN0: begin
                        state_next.c0.enable = regWdata[`DCC_CN_EN];
                        state_next.c0.posHyst = regWdata[`DCC_CN_HYP +: 2];
                        state_next.c0.negHyst = regWdata[`DCC_CN_HYN +: 2];
                    end
                    `DCC_OFF_CN1: begin
                        state_next.c1.enable = regWdata[`DCC_CN_EN];
                        state_next.c1.posHyst = regWdata[`DCC_CN_HYP +: 2];
                        state_next.c1.negHyst = regWdata[`DCC_CN_HYN +: 2];
                    end
                    `DCC_OFF_MD0: begin
                        state_next.c0.respMode = regWdata[`DCC_MD_MODE +: 2];
                        state_next.c0.riseIrqEn = regWdata[`DCC_MD_RIE];
                        state_next.c0.fallIrqEn = regWdata[`DCC_MD_FIE];
                    end
                    `DCC_OFF_MD1: begin
                        state_next.c1.respMode = regWdata[`DCC_MD_MODE +: 2];
                        state_next.c1.riseIrqEn = regWdata[`DCC_MD_RIE];
                        state_next.c1.fallIrqEn = regWdata[`DCC_MD_FIE];
                    end
                    `DCC_OFF_MX0: begin
                        state_next.c0.posSel = regWdata[`DCC_MX_POS +: 2];
                        state_next.c0.negSel = regWdata[`DCC_MX_NEG +: 2];
                    end
                    `DCC_OFF_MX1: begin
                        state_next.c1.posSel = regWdata[`DCC_MX_POS +: 2];
                        state_next.c1.negSel = regWdata[`DCC_MX_NEG +: 2];
                    end
                    `DCC_OFF_RST: begin
                        state_next.resetSrcEn = regWdata[`DCC_RST_EN];
                    end
                    default: begin
                    end
                endcase
            end
            state_next.rdata = 8'h00;
            if (regRd) begin
                unique case (regAddr)
                    `DCC_OFF_CN0: begin
                        state_next.rdata = cnRead(state_reg.c0, stat0.result, rise0, fall0);
                    end
                    `DCC_OFF_CN1: begin
                        state_next.rdata = cnRead(state_reg.c1, stat1.result, rise1, fall1);
                    end
                    `DCC_OFF_MD0: state_next.rdata = mdRead(state_reg.c0);
                    `DCC_OFF_MD1: state_next.rdata = mdRead(state_reg.c1);
                    `DCC_OFF_MX0: state_next.rdata = mxRead(state_reg.c0);
                    `DCC_OFF_MX1: state_next.rdata = mxRead(state_reg.c1);
                    `DCC_OFF_RST: state_next.rdata = rstRead(state_reg.resetSrcEn);
                    default: state_next.rdata = 8'h00;
                endcase
            end
            // unit 0 reset source
            // A disabled comparator reads low, so the enable term keeps it from resetting.
            state_next.resetReq = state_reg.resetSrcEn & state_reg.c0.enable & ~stat0.latched;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= topReset();
        end else begin
            state_reg <= state_next;
        end
    end

    assign cmp0_latched_out = stat0.latched;
    assign cmp1_latched_out = stat1.latched;
    assign cmp0Irq = stat0.irq;
    assign cmp1Irq = stat1.irq;
    assign regRdata = state_reg.rdata;
    assign cmpResetReq = state_reg.resetReq;

    always_comb begin
        cmp0Analog.posSel = state_reg.c0.posSel;
        cmp0Analog.negSel = state_reg.c0.negSel;
        cmp0Analog.posHyst = state_reg.c0.posHyst;
        cmp0Analog.negHyst = state_reg.c0.negHyst;
        cmp0Analog.respMode = state_reg.c0.respMode;
        cmp0Analog.enable = state_reg.c0.enable;
        cmp1Analog.posSel = state_reg.c1.posSel;
        cmp1Analog.negSel = state_reg.c1.negSel;
        cmp1Analog.posHyst = state_reg.c1.posHyst;
        cmp1Analog.negHyst = state_reg.c1.negHyst;
        cmp1Analog.respMode = state_reg.c1.respMode;
        cmp1Analog.enable = state_reg.c1.enable;
    end
endmodule

//--- verif/dcc_props.sv
/*
 * Port-level assertions of the dual comparator control block.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module dcc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [`DCC_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic rawCmp0,
    input wire logic rawCmp1,
    input wire logic cmp0_raw_out,
    input wire logic cmp1_raw_out,
    input wire logic cmp0_latched_out,
    input wire logic cmp1_latched_out,
    input wire logic cmpResetReq,
    input wire dcc_pkg::dcc_analog_t cmp0Analog,
    input wire dcc_pkg::dcc_analog_t cmp1Analog
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [7:0] wdPrev;

    always_ff @(posedge clk) begin
        wdPrev <= regWdata;
    end

    raw_gate_off_a: assert property (!cmp0Analog.enable |-> !cmp0_raw_out)
        else $error("raw output high while disabled");
    raw_follow_a: assert property (cmp1Analog.enable |-> cmp1_raw_out == rawCmp1)
        else $error("raw output does not follow comparator");
    latch_sync_a: assert property ((cmp0Analog.enable && clkEn && $stable(rawCmp0))[*4]
        |-> cmp0_latched_out == rawCmp0) else $error("latched output lags too long");
    latch_off_a: assert property ((!cmp1Analog.enable && clkEn)[*2] |-> !cmp1_latched_out)
        else $error("latched output high while disabled");
    reset_src_a: assert property (cmpResetReq && $past(clkEn) |-> !$past(cmp0_latched_out))
        else $error("reset request while comparator high");
    read_idle_a: assert property ($past(clkEn) && !$past(regRd) |-> regRdata == 8'h00)
        else $error("read data outside read cycle");
    mode_reset_a: assert property ($past(sys_rst) |-> cmp0Analog.respMode == 2'h2
        && cmp1Analog.respMode == 2'h2 && !cmp0Analog.enable) else $error("bad reset mode");
    sel_write_a: assert property (regWr && clkEn && regAddr == `DCC_OFF_MX0 |=>
        cmp0Analog.posSel == wdPrev[1:0] && cmp0Analog.negSel == wdPrev[5:4])
        else $error("input select not updated");
    hyst_write_a: assert property (regWr && clkEn && regAddr == `DCC_OFF_CN1 |=>
        cmp1Analog.posHyst == wdPrev[3:2] && cmp1Analog.negHyst == wdPrev[1:0]
        && cmp1Analog.enable == wdPrev[7]) else $error("control not updated");
    mode_write_a: assert property (regWr && clkEn && regAddr == `DCC_OFF_MD0 |=>
        cmp0Analog.respMode == wdPrev[1:0]) else $error("response mode not updated");
endmodule

bind dcc_top dcc_props props_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rawCmp0(rawCmp0), .rawCmp1(rawCmp1),
    .cmp0_raw_out(cmp0_raw_out), .cmp1_raw_out(cmp1_raw_out),
    .cmp0_latched_out(cmp0_latched_out), .cmp1_latched_out(cmp1_latched_out),
    .cmpResetReq(cmpResetReq), .cmp0Analog(cmp0Analog), .cmp1Analog(cmp1Analog));

//--- verif/dcc_analog_model.sv
/*
 * Analog side of both comparators: four pin levels per input, in mV.
 * Assumes the bench drives the pin levels and the block drives the selects.
 */
`timescale 1ns/10ps

module dcc_analog_model (
    input wire logic clk,
    input wire dcc_pkg::dcc_analog_t an0,
    input wire dcc_pkg::dcc_analog_t an1,
    input wire logic [31:0] posMv0,
    input wire logic [31:0] negMv0,
    input wire logic [31:0] posMv1,
    input wire logic [31:0] negMv1,
    output logic rawCmp0,
    output logic rawCmp1
);
    logic junk = 1'b0;

    // A powered-down comparator has no defined answer, so it chatters.
    always @(posedge clk) begin
        junk <= !junk;
    end

    always_comb begin
        rawCmp0 = an0.enable ? posMv0[an0.posSel*8 +: 8] > negMv0[an0.negSel*8 +: 8] : junk;
        rawCmp1 = an1.enable ? posMv1[an1.posSel*8 +: 8] > negMv1[an1.negSel*8 +: 8] : junk;
    end
endmodule

//--- verif/tb_top.sv
/*
 * Register-level test of the dual comparator control block.
 * Assumes the analog model in front of the comparator inputs.
 */
`timescale 1ns/10ps
`include "dcc_cfg.svh"

module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic [`DCC_ADDR_W-1:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    logic rawCmp0, rawCmp1, raw0, raw1, lat0, lat1, irq0, irq1, rstReq;
    dcc_pkg::dcc_analog_t an0, an1;
    logic [31:0] posMv0 = 32'h40404040;
    logic [31:0] negMv0 = 32'h30303030;
    logic [31:0] posMv1 = 32'h10203040;
    logic [31:0] negMv1 = 32'h25252525;
    int testsRun = 0;
    int failCount = 0;

    initial begin
        forever #4 clk = ~clk;
    end

    dcc_top dut_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rawCmp0(rawCmp0), .rawCmp1(rawCmp1), .cmp0_raw_out(raw0), .cmp1_raw_out(raw1),
        .cmp0_latched_out(lat0), .cmp1_latched_out(lat1), .cmp0Irq(irq0), .cmp1Irq(irq1),
        .cmpResetReq(rstReq), .cmp0Analog(an0), .cmp1Analog(an1));

    dcc_analog_model model_u (.clk(clk), .an0(an0), .an1(an1), .posMv0(posMv0),
        .negMv0(negMv0), .posMv1(posMv1), .negMv1(negMv1), .rawCmp0(rawCmp0),
        .rawCmp1(rawCmp1));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            failCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check(what, regRdata, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic results;
        if (failCount == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #20000;
        failCount++;
        results();
    end

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdChk("cn0", `DCC_OFF_CN0, 8'h00);
        rdChk("md0", `DCC_OFF_MD0, 8'h02);
        rdChk("md1", `DCC_OFF_MD1, 8'h02);
        rdChk("mx1", `DCC_OFF_MX1, 8'h00);
        wr(8'h55, 8'hff);
        rdChk("hole", 8'h55, 8'h00);
        wr(`DCC_OFF_MX0, 8'hff);
        rdChk("mx0", `DCC_OFF_MX0, 8'h33);
        for (int i = 0; i < 4; i++) begin
            wr(`DCC_OFF_MD1, 8'hf0 | 8'(i));
            rdChk("md1 mode", `DCC_OFF_MD1, 8'h30 | 8'(i));
            wr(`DCC_OFF_CN1, 8'h70 | 8'(i * 5));
            rdChk("cn1 hyst", `DCC_OFF_CN1, 8'(i * 5));
        end
        wr(`DCC_OFF_CN0, 8'h8f);
        idle(6);
        rdChk("cn0 on", `DCC_OFF_CN0, 8'hef);
        wr(`DCC_OFF_CN0, 8'h8f);
        rdChk("cn0 clr", `DCC_OFF_CN0, 8'hcf);
        wr(`DCC_OFF_MD0, 8'h12);
        posMv0 <= 32'h20202020;
        idle(6);
        check("irq0 fall", {7'h00, irq0}, 8'h01);
        check("raw0 low", {7'h00, raw0}, 8'h00);
        posMv0 <= 32'h40404040;
        idle(6);
        rdChk("cn0 both", `DCC_OFF_CN0, 8'hff);
        wr(`DCC_OFF_CN0, 8'h9f);
        rdChk("cn0 fif", `DCC_OFF_CN0, 8'hdf);
        check("irq0 held", {7'h00, irq0}, 8'h01);
        wr(`DCC_OFF_CN0, 8'h8f);
        idle(2);
        check("irq0 off", {7'h00, irq0}, 8'h00);
        clkEn <= 1'b0;
        posMv0 <= 32'h20202020;
        wr(`DCC_OFF_MD0, 8'h00);
        check("raw0 stop", {7'h00, raw0}, 8'h00);
        check("lat0 held", {7'h00, lat0}, 8'h01);
        clkEn <= 1'b1;
        idle(5);
        check("lat0 low", {7'h00, lat0}, 8'h00);
        rdChk("md0 frozen", `DCC_OFF_MD0, 8'h12);
        wr(`DCC_OFF_RST, 8'h01);
        idle(3);
        check("reset req", {7'h00, rstReq}, 8'h01);
        posMv0 <= 32'h40404040;
        idle(6);
        check("reset idle", {7'h00, rstReq}, 8'h00);
        rdChk("rst src", `DCC_OFF_RST, 8'h01);
        wr(`DCC_OFF_MX1, 8'h02);
        wr(`DCC_OFF_CN1, 8'h80);
        idle(6);
        rdChk("cn1 low", `DCC_OFF_CN1, 8'h80);
        wr(`DCC_OFF_MX1, 8'h01);
        idle(6);
        rdChk("cn1 rise", `DCC_OFF_CN1, 8'he0);
        check("irq1", {7'h00, irq1}, 8'h01);
        check("lat1", {7'h00, lat1}, 8'h01);
        check("raw1", {7'h00, raw1}, 8'h01);
        check("reset unit1", {7'h00, rstReq}, 8'h00);
        idle(1);
        posMv1 <= 32'h10201040;
        idle(1);
        wr(`DCC_OFF_CN1, 8'h80);
        rdChk("cn1 set wins", `DCC_OFF_CN1, 8'h90);
        wr(`DCC_OFF_CN0, 8'h00);
        idle(4);
        check("raw0 off", {7'h00, raw0}, 8'h00);
        check("lat0 off", {7'h00, lat0}, 8'h00);
        rdChk("cn0 off", `DCC_OFF_CN0, 8'h10);
        results();
    end
endmodule
